// >>> bpm_ctrl.sv
/*
  Power-mode controller: ship, high-impedance, active battery, charging and sleep,
  with discharge switch short-circuit retry and the battery monitor latch.
  Assumes analog comparator levels and pins arrive asynchronously and are
  synchronised here, while host bits come from register logic on SYS_CLK.
*/
// Overview of operation
// - No ship entry while input supply valid.
// - Ship via host request or long press.
// - Pending ship request acts on input removal.
// - Ship needs pins high, stable quiet time.
// - Ship exits on input or held button.
// - Ship senses button without clock or delay.
// - Adapter during long press arms later ship.
// - Button powers middle node, exit after hold.
// - High-impedance keeps output and load switch.
// - Charge pin picks mode per input level.
// - High-impedance request disables bus till toggle.
// - Output rises after battery deglitch time.
// - Short circuit: switch off, recover, retry.
// - Switch off below battery lockout, hysteresis.
// - Input arrival enables supplement above minimum.
// - Charging needs pin low and enable bit.
// - Host interfaces ready 5 ms after output.
// - Monitor samples before high-impedance or trigger.
// - Monitor level in 2% steps, 60-100%.
// - Sleep entry pulses interrupt, sets fault.
// - Quiet interval lasts at most 1 ms.
// - Wake hold time selectable 0.08 to 1 s.
module bpm_ctrl
  import bpm_pkg::*;
#(
  parameter int unsigned P_QUIET_CYC = QUIET_CYC,
  parameter int unsigned P_WAKE_SHORT_CYC = WAKE_SHORT_CYC,
  parameter int unsigned P_WAKE_LONG_CYC = WAKE_LONG_CYC,
  parameter int unsigned P_RESET_HOLD_CYC = RESET_HOLD_CYC,
  parameter int unsigned P_BAT_DGL_CYC = BAT_DGL_CYC,
  parameter int unsigned P_SC_DGL_CYC = SC_DGL_CYC,
  parameter int unsigned P_SC_REC_CYC = SC_REC_CYC,
  parameter int unsigned P_HOST_READY_CYC = HOST_READY_CYC,
  parameter int unsigned P_MON_CYC = MON_CYC,
  parameter int unsigned P_INT_PULSE_CYC = INT_PULSE_CYC
)
(
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic IN_UVLO_OK,
  input wire logic IN_ABOVE_SLEEP,
  input wire logic BAT_ABOVE_UVLO,
  input wire logic BAT_ABOVE_HYST,
  input wire logic BAT_ABOVE_MIN,
  input wire logic BAT_ABOVE_MAX,
  input wire logic SC_LIMIT,
  input wire logic SYS_IN_REG,
  input wire logic PUSH_BUTTON_N,
  input wire logic CHARGE_DISABLE_PIN,
  input wire logic LOAD_SWITCH_CONTROL,
  input wire logic [6:0] BAT_PERCENT,
  input wire logic SHIP_MODE_REQUEST,
  input wire logic BUTTON_LONG_PRESS_ACTION,
  input wire logic HIGH_IMPEDANCE_REQUEST,
  input wire logic BATTERY_MONITOR_TRIGGER,
  input wire logic CHARGE_ENABLE_N,
  input wire logic LS_I2C_ENABLE,
  input wire logic WAKE_HOLD_SEL,
  input wire logic FAULT_READ,
  output logic [4:0] POWER_MODE,
  output logic BAT_SWITCH_ON,
  output logic SUPPLEMENT_ON,
  output logic SYS_OUTPUT_ENABLE,
  output logic MIDDLE_POWER_NODE_ON,
  output logic MIDDLE_POWER_NODE_PULLDOWN,
  output logic LOAD_SWITCH_ON,
  output logic CHARGE_ON,
  output logic CHARGE_CYCLE_START,
  output logic INTERRUPT_PULSE,
  output logic SLEEP_FAULT,
  output logic I2C_ENABLE,
  output logic HOST_IF_READY,
  output logic [4:0] BATTERY_MONITOR_LEVEL,
  output logic MONITOR_BUSY
);

  typedef struct packed {
    bpm_mode_e mode;
    bpm_sense_s sync1;
    bpm_sense_s sync2;
    logic [6:0] pct1;
    logic [6:0] pct2;
    logic cd_prev;
    logic pb_prev;
    logic in_prev;
    bpm_cnt_t quiet_cnt;
    bpm_cnt_t pb_cnt;
    bpm_cnt_t arm_cnt;
    bpm_cnt_t bat_cnt;
    bpm_cnt_t sc_cnt;
    bpm_cnt_t host_cnt;
    bpm_cnt_t mon_cnt;
    bpm_cnt_t int_cnt;
    logic long_press;
    logic btn_ship;
    logic btn_armed;
    logic bat_ok;
    logic sys_en;
    logic sc_off;
    logic host_ready;
    logic i2c_off;
    logic hiz_sampled;
    logic mon_busy;
    logic [4:0] mon_level;
    logic int_on;
    logic sleep_fault;
    logic ls_latched;
    logic charge_start;
  } bpm_state_s;

  bpm_state_s state_reg;
  bpm_state_s state_next;
  bpm_sense_s sense_in;
  bpm_sense_s v;
  logic batt_only;
  logic ship_pend;
  logic ship_cond;
  logic pins_changed;
  logic hiz_want;
  logic sw_want;
  logic mon_start;
  logic to_sleep;
  bpm_cnt_t wake_cyc;

  function automatic bpm_cnt_t cnt_step(input bpm_cnt_t cnt, input logic run);
    bpm_cnt_t r;
    r = '0;
    if (run)
    begin
      r = (cnt == CNT_MAX) ? cnt : cnt + 32'h1;
    end
    return r;
  endfunction

  function automatic logic [4:0] mon_code(input logic [6:0] pct);
    logic [6:0] d;
    logic [4:0] r;
    d = pct - MON_MIN_PCT;
    r = d[5:1];
    if (pct < MON_MIN_PCT)
    begin
      r = 5'h00;
    end
    else if (pct > MON_MAX_PCT)
    begin
      r = MON_TOP_CODE;
    end
    return r;
  endfunction

  assign sense_in = '{IN_UVLO_OK, IN_ABOVE_SLEEP, BAT_ABOVE_UVLO, BAT_ABOVE_HYST,
                      BAT_ABOVE_MIN, BAT_ABOVE_MAX, SC_LIMIT, SYS_IN_REG,
                      PUSH_BUTTON_N, CHARGE_DISABLE_PIN, LOAD_SWITCH_CONTROL};
  assign v = state_reg.sync2;
  assign batt_only = !v.in_uvlo_ok;
  assign wake_cyc = WAKE_HOLD_SEL ? P_WAKE_LONG_CYC : P_WAKE_SHORT_CYC;
  assign ship_pend = SHIP_MODE_REQUEST | state_reg.btn_ship;
  assign pins_changed = (v.charge_disable != state_reg.cd_prev) |
                        (v.push_button_n != state_reg.pb_prev);
  // Both ship conditions are checked while the input is low and the pins are high.
  assign ship_cond = ship_pend & batt_only & v.charge_disable & v.push_button_n;
  assign hiz_want = !v.charge_disable | state_reg.i2c_off;
  assign to_sleep = v.in_uvlo_ok & !v.in_above_sleep;
  assign mon_start = BATTERY_MONITOR_TRIGGER |
                     (state_reg.mode == ST_ACTBAT & batt_only & hiz_want &
                      !state_reg.hiz_sampled & !ship_cond);
  // Supplement path in charge mode, battery path in other modes except ship, where it stays off.
  assign sw_want = (state_reg.mode == ST_CHARGE) ? v.bat_above_min :
                   (state_reg.mode != ST_SHIP) & state_reg.bat_ok;

  always_comb
  begin
    state_next = state_reg;
    state_next.sync1 = sense_in;
    state_next.sync2 = state_reg.sync1;
    state_next.pct1 = BAT_PERCENT;
    state_next.pct2 = state_reg.pct1;
    state_next.cd_prev = v.charge_disable;
    state_next.pb_prev = v.push_button_n;
    state_next.in_prev = v.in_uvlo_ok;
    state_next.charge_start = 1'b0;

    state_next.pb_cnt = cnt_step(state_reg.pb_cnt, !v.push_button_n);
    if (state_reg.pb_cnt == P_RESET_HOLD_CYC)
    begin
      state_next.long_press = 1'b1;
    end
    // An adapter plugged in during a finished long press arms ship for removal.
    if (v.in_uvlo_ok & !state_reg.in_prev & state_reg.long_press)
    begin
      state_next.btn_armed = 1'b1;
    end
    state_next.arm_cnt = cnt_step(state_reg.arm_cnt, state_reg.btn_armed & !v.push_button_n);
    if (state_reg.btn_armed & state_reg.arm_cnt >= wake_cyc)
    begin
      state_next.btn_armed = 1'b0;
      state_next.long_press = 1'b0;
    end
    if (v.push_button_n & state_reg.long_press)
    begin
      state_next.long_press = 1'b0;
      if (!BUTTON_LONG_PRESS_ACTION & (batt_only | state_reg.btn_armed))
      begin
        state_next.btn_ship = 1'b1;
      end
      state_next.btn_armed = 1'b0;
    end

    state_next.quiet_cnt = cnt_step(state_reg.quiet_cnt, ship_cond & !pins_changed);

    if (state_reg.cd_prev != v.charge_disable)
    begin
      state_next.i2c_off = 1'b0;
    end
    if (HIGH_IMPEDANCE_REQUEST & batt_only)
    begin
      state_next.i2c_off = 1'b1;
    end

    state_next.int_cnt = cnt_step(state_reg.int_cnt, state_reg.int_on);
    if (state_reg.int_on & state_reg.int_cnt >= P_INT_PULSE_CYC - 1)
    begin
      state_next.int_on = 1'b0;
    end
    // A read in the same cycle as a new sleep entry loses to the set below.
    if (FAULT_READ & state_reg.mode != ST_SLEEP)
    begin
      state_next.sleep_fault = 1'b0;
    end

    unique case (state_reg.mode)
      ST_SHIP:
      begin
        if (v.in_uvlo_ok & v.in_above_sleep)
        begin
          state_next.mode = ST_CHARGE;
        end
        else if (v.push_button_n & !state_reg.pb_prev & v.bat_above_max &
                 state_reg.pb_cnt >= wake_cyc)
        begin
          state_next.mode = ST_ACTBAT;
        end
      end
      ST_HIZ, ST_ACTBAT:
      begin
        if (v.in_uvlo_ok)
        begin
          state_next.mode = to_sleep ? ST_SLEEP : ST_CHARGE;
          state_next.hiz_sampled = 1'b0;
        end
        else if (ship_cond & state_reg.quiet_cnt >= P_QUIET_CYC - 1)
        begin
          state_next.mode = ST_SHIP;
          state_next.btn_ship = 1'b0;
          state_next.hiz_sampled = 1'b0;
        end
        else if (state_reg.mode == ST_HIZ)
        begin
          if (!hiz_want)
          begin
            state_next.mode = ST_ACTBAT;
          end
        end
        else if (!hiz_want)
        begin
          state_next.hiz_sampled = 1'b0;
        end
        else if (mon_start)
        begin
          state_next.hiz_sampled = 1'b1;
        end
        else if (state_reg.hiz_sampled & !state_reg.mon_busy & !ship_cond)
        begin
          state_next.mode = ST_HIZ;
          state_next.hiz_sampled = 1'b0;
          state_next.ls_latched = LS_I2C_ENABLE;
        end
      end
      ST_CHARGE:
      begin
        if (batt_only)
        begin
          state_next.mode = ST_ACTBAT;
        end
        else if (to_sleep)
        begin
          state_next.mode = ST_SLEEP;
        end
      end
      ST_SLEEP:
      begin
        if (batt_only)
        begin
          state_next.mode = ST_ACTBAT;
        end
        else if (v.in_above_sleep)
        begin
          state_next.mode = ST_CHARGE;
          state_next.charge_start = 1'b1;
        end
      end
      default:
      begin
        state_next.mode = ST_ACTBAT;
      end
    endcase

    if (state_next.mode == ST_SLEEP & state_reg.mode != ST_SLEEP)
    begin
      state_next.int_on = 1'b1;
      state_next.int_cnt = '0;
      state_next.sleep_fault = 1'b1;
    end

    // Retriggering restarts the window, so the result always follows the last start.
    state_next.mon_cnt = cnt_step(state_reg.mon_cnt, state_reg.mon_busy);
    if (mon_start)
    begin
      state_next.mon_busy = 1'b1;
      state_next.mon_cnt = '0;
    end
    else if (state_reg.mon_busy & state_reg.mon_cnt >= P_MON_CYC - 1)
    begin
      state_next.mon_busy = 1'b0;
      state_next.mon_level = mon_code(state_reg.pct2);
    end

    if (!v.bat_above_uvlo)
    begin
      state_next.bat_ok = 1'b0;
    end
    else if (v.bat_above_hyst)
    begin
      state_next.bat_ok = 1'b1;
    end
    state_next.bat_cnt = cnt_step(state_reg.bat_cnt, state_reg.bat_ok);
    state_next.sys_en = (state_next.mode != ST_SHIP) &
                        (v.in_uvlo_ok | (state_reg.bat_ok &
                         state_reg.bat_cnt >= P_BAT_DGL_CYC - 1));

    if (state_reg.sc_off)
    begin
      state_next.sc_cnt = cnt_step(state_reg.sc_cnt, 1'b1);
      if (state_reg.sc_cnt >= P_SC_REC_CYC - 1)
      begin
        state_next.sc_off = 1'b0;
        state_next.sc_cnt = '0;
      end
    end
    else
    begin
      state_next.sc_cnt = cnt_step(state_reg.sc_cnt, sw_want & v.sc_limit);
      if (state_reg.sc_cnt >= P_SC_DGL_CYC - 1)
      begin
        state_next.sc_off = 1'b1;
        state_next.sc_cnt = '0;
      end
    end

    state_next.host_cnt = cnt_step(state_reg.host_cnt, state_reg.sys_en & v.sys_in_reg);
    state_next.host_ready = state_reg.sys_en & v.sys_in_reg &
                            (state_reg.host_ready |
                             state_reg.host_cnt >= P_HOST_READY_CYC - 1);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (!NRST)
    begin
      state_reg <= '0;
      state_reg.mode <= ST_ACTBAT;
      // The button idles high; starting there avoids a false press after reset.
      state_reg.pb_prev <= 1'b1;
      state_reg.sync1.push_button_n <= 1'b1;
      state_reg.sync2.push_button_n <= 1'b1;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign POWER_MODE = state_reg.mode;
  assign BAT_SWITCH_ON = sw_want & !state_reg.sc_off;
  assign SUPPLEMENT_ON = (state_reg.mode == ST_CHARGE) & v.bat_above_min;
  assign SYS_OUTPUT_ENABLE = state_reg.sys_en;
  // The button is read straight from the pin in ship mode, with no clocked path.
  assign MIDDLE_POWER_NODE_ON = (state_reg.mode != ST_SHIP) | !PUSH_BUTTON_N;
  assign MIDDLE_POWER_NODE_PULLDOWN = (state_reg.mode == ST_SHIP) & PUSH_BUTTON_N;
  assign LOAD_SWITCH_ON = (state_reg.mode == ST_SHIP) ? 1'b0 :
                          (state_reg.mode == ST_HIZ) ? (state_reg.ls_latched | v.load_switch_control) :
                          (LS_I2C_ENABLE | v.load_switch_control);
  assign CHARGE_ON = (state_reg.mode == ST_CHARGE) & !v.charge_disable &
                     !CHARGE_ENABLE_N;
  assign CHARGE_CYCLE_START = state_reg.charge_start;
  assign INTERRUPT_PULSE = state_reg.int_on;
  assign SLEEP_FAULT = state_reg.sleep_fault;
  assign I2C_ENABLE = state_reg.host_ready & !state_reg.i2c_off &
                      (state_reg.mode != ST_SHIP);
  assign HOST_IF_READY = state_reg.host_ready;
  assign BATTERY_MONITOR_LEVEL = state_reg.mon_level;
  assign MONITOR_BUSY = state_reg.mon_busy;

  property p_ship_no_input;
    @(posedge SYS_CLK) disable iff (!NRST)
    (state_reg.mode == ST_SHIP) && ($past(state_reg.mode) != ST_SHIP) && $past(NRST)
      |-> !$past(v.in_uvlo_ok) && $past(v.charge_disable) && $past(v.push_button_n);
  endproperty
  a_ship_no_input: assert property (p_ship_no_input) else $error("ship entered illegally");

  property p_one_hot;
    @(posedge SYS_CLK) disable iff (!NRST)
    $onehot(state_reg.mode);
  endproperty
  a_one_hot: assert property (p_one_hot) else $error("mode not one-hot");

  property p_charge_gate;
    @(posedge SYS_CLK) disable iff (!NRST)
    CHARGE_ON |-> state_reg.mode == ST_CHARGE && !CHARGE_ENABLE_N && !v.charge_disable;
  endproperty
  a_charge_gate: assert property (p_charge_gate) else $error("charging while disabled");

  property p_sleep_int;
    @(posedge SYS_CLK) disable iff (!NRST)
    (state_reg.mode == ST_SLEEP) && ($past(state_reg.mode) != ST_SLEEP)
      |-> INTERRUPT_PULSE && SLEEP_FAULT;
  endproperty
  a_sleep_int: assert property (p_sleep_int) else $error("no pulse on sleep entry");

  property p_fault_held;
    @(posedge SYS_CLK) disable iff (!NRST)
    state_reg.mode == ST_SLEEP |-> SLEEP_FAULT;
  endproperty
  a_fault_held: assert property (p_fault_held) else $error("fault lost in sleep");

  property p_sc_off;
    @(posedge SYS_CLK) disable iff (!NRST)
    $rose(state_reg.sc_off) |-> !BAT_SWITCH_ON [*2];
  endproperty
  a_sc_off: assert property (p_sc_off) else $error("switch on during recovery");

  property p_hiz_bus_off;
    @(posedge SYS_CLK) disable iff (!NRST)
    HIGH_IMPEDANCE_REQUEST && batt_only |=> !I2C_ENABLE;
  endproperty
  a_hiz_bus_off: assert property (p_hiz_bus_off) else $error("bus still on");

  property p_ship_off;
    @(posedge SYS_CLK) disable iff (!NRST)
    state_reg.mode == ST_SHIP |-> !BAT_SWITCH_ON && !LOAD_SWITCH_ON && !I2C_ENABLE;
  endproperty
  a_ship_off: assert property (p_ship_off) else $error("outputs on in ship");

  property p_mon_range;
    @(posedge SYS_CLK) disable iff (!NRST)
    BATTERY_MONITOR_LEVEL <= MON_TOP_CODE;
  endproperty
  a_mon_range: assert property (p_mon_range) else $error("monitor code out of range");

  property p_uvlo_off;
    @(posedge SYS_CLK) disable iff (!NRST)
    !v.bat_above_uvlo && state_reg.mode == ST_ACTBAT |=> !BAT_SWITCH_ON;
  endproperty
  a_uvlo_off: assert property (p_uvlo_off) else $error("switch on below lockout");

endmodule

// >>> bpm_pkg.sv
/*
  Shared constants and types for the battery power-mode controller.
  Assumes a 100 MHz system clock and time constants given in their own units.
*/
package bpm_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1_000;

  // Longest quiet interval before the ship transition completes.
  localparam int unsigned QUIET_TIME_MS = 1;
  localparam int unsigned QUIET_CYC = QUIET_TIME_MS * CYC_PER_MS;
  // Wake hold time, selectable between its two ends.
  localparam int unsigned WAKE_SHORT_MS = 80;
  localparam int unsigned WAKE_LONG_MS = 1000;
  localparam int unsigned WAKE_SHORT_CYC = WAKE_SHORT_MS * CYC_PER_MS;
  localparam int unsigned WAKE_LONG_CYC = WAKE_LONG_MS * CYC_PER_MS;
  localparam int unsigned RESET_HOLD_MS = 5000;
  localparam int unsigned RESET_HOLD_CYC = RESET_HOLD_MS * CYC_PER_MS;
  localparam int unsigned BAT_DGL_US = 1000;
  localparam int unsigned BAT_DGL_CYC = BAT_DGL_US * CYC_PER_US;
  localparam int unsigned SC_DGL_US = 100;
  localparam int unsigned SC_DGL_CYC = SC_DGL_US * CYC_PER_US;
  localparam int unsigned SC_REC_MS = 100;
  localparam int unsigned SC_REC_CYC = SC_REC_MS * CYC_PER_MS;
  localparam int unsigned HOST_READY_MS = 5;
  localparam int unsigned HOST_READY_CYC = HOST_READY_MS * CYC_PER_MS;
  localparam int unsigned MON_MS = 2;
  localparam int unsigned MON_CYC = MON_MS * CYC_PER_MS;
  localparam int unsigned INT_PULSE_US = 128;
  localparam int unsigned INT_PULSE_CYC = INT_PULSE_US * CYC_PER_US;

  localparam logic [6:0] MON_MIN_PCT = 7'h3C;
  localparam logic [6:0] MON_MAX_PCT = 7'h64;
  localparam logic [4:0] MON_TOP_CODE = 5'h14;
  localparam logic [31:0] CNT_MAX = 32'hFFFFFFFF;

  typedef logic [31:0] bpm_cnt_t;

  typedef enum logic [4:0] {
    ST_SHIP = 5'h01,
    ST_HIZ = 5'h02,
    ST_ACTBAT = 5'h04,
    ST_CHARGE = 5'h08,
    ST_SLEEP = 5'h10
  } bpm_mode_e;

  typedef struct packed {
    logic in_uvlo_ok;
    logic in_above_sleep;
    logic bat_above_uvlo;
    logic bat_above_hyst;
    logic bat_above_min;
    logic bat_above_max;
    logic sc_limit;
    logic sys_in_reg;
    logic push_button_n;
    logic charge_disable;
    logic load_switch_control;
  } bpm_sense_s;

endpackage

// >>> bpm_host_model.sv
/*
  Host controller model: holds the register bits and write strobes of the host.
  Assumes the bench calls its tasks and that the block samples on SYS_CLK.
*/
module bpm_host_model
  import bpm_pkg::*;
(
  input wire logic sys_clk,
  output logic ship_req,
  output logic long_act,
  output logic hiz_req,
  output logic mon_trig,
  output logic ce_n,
  output logic ls_en,
  output logic wake_sel,
  output logic fault_rd
);
  timeunit 1ns;
  timeprecision 100ps;

  // Long press action starts at 1, so a held button asks for ship only once cleared.
  initial
  begin
    ship_req = 1'b0;
    long_act = 1'b1;
    hiz_req = 1'b0;
    mon_trig = 1'b0;
    ce_n = 1'b0;
    ls_en = 1'b1;
    wake_sel = 1'b0;
    fault_rd = 1'b0;
  end

  task automatic set_ship(input logic v);
    @(posedge sys_clk) ship_req <= v;
  endtask

  // Bits in order: long press action, charge disable, load switch enable, wake select.
  task automatic set_cfg(input logic [3:0] c);
    @(posedge sys_clk) {long_act, ce_n, ls_en, wake_sel} <= c;
    #1;
  endtask

  // Strobes last one cycle; 0 monitor, 1 high impedance, 2 fault read.
  // The strobe leaves the charge enable bit ce_n as it is for every strobe.
  task automatic strobe(input int k);
    @(posedge sys_clk)
    begin
      mon_trig <= (k == 0);
      hiz_req <= (k == 1);
      fault_rd <= (k == 2);
    end
    @(posedge sys_clk)
    begin
      mon_trig <= 1'b0;
      hiz_req <= 1'b0;
      fault_rd <= 1'b0;
    end
    // Return after the edge so that the caller sees settled outputs.
    #1;
  endtask
endmodule

// >>> tb_top.sv
/*
  Self-checking bench of the power-mode controller with shortened counts.
  Assumes the host model drives the host bits and the bench drives pins.
*/
module tb_top;
  import bpm_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic SYS_CLK = 1'b0;
  logic NRST = 1'b0;
  logic IN_UVLO_OK = 1'b0, IN_ABOVE_SLEEP = 1'b0, SC_LIMIT = 1'b0;
  logic BAT_UV = 1'b1, BAT_HY = 1'b1, BAT_MIN = 1'b1, BAT_MAX = 1'b1;
  logic PB_N = 1'b1, CD = 1'b1, LSC = 1'b0;
  logic [6:0] BAT_PCT = 7'h50;
  logic ship_req, long_act, hiz_req, mon_trig, ce_n, ls_en, wake_sel, fault_rd;
  logic [4:0] POWER_MODE, LEVEL;
  logic BAT_SW, SUPP, SYS_EN, MID_ON, MID_PD, LS_ON, CHG_ON, CYC_START;
  logic INT_P, FAULT, I2C_EN, HOST_RDY, MON_BUSY;
  int err_total = 0;
  int total_checks = 0;

  always #5 SYS_CLK = ~SYS_CLK;

  bpm_host_model HOST (.sys_clk(SYS_CLK), .ship_req(ship_req), .long_act(long_act),
    .hiz_req(hiz_req), .mon_trig(mon_trig), .ce_n(ce_n), .ls_en(ls_en),
    .wake_sel(wake_sel), .fault_rd(fault_rd));

  bpm_ctrl #(.P_QUIET_CYC(20), .P_WAKE_SHORT_CYC(30), .P_WAKE_LONG_CYC(60),
    .P_RESET_HOLD_CYC(50), .P_BAT_DGL_CYC(10), .P_SC_DGL_CYC(5), .P_SC_REC_CYC(20),
    .P_HOST_READY_CYC(40), .P_MON_CYC(25), .P_INT_PULSE_CYC(12)) DUT (
    .SYS_CLK(SYS_CLK), .NRST(NRST), .IN_UVLO_OK(IN_UVLO_OK),
    .IN_ABOVE_SLEEP(IN_ABOVE_SLEEP), .BAT_ABOVE_UVLO(BAT_UV), .BAT_ABOVE_HYST(BAT_HY),
    .BAT_ABOVE_MIN(BAT_MIN), .BAT_ABOVE_MAX(BAT_MAX), .SC_LIMIT(SC_LIMIT),
    .SYS_IN_REG(SYS_EN), .PUSH_BUTTON_N(PB_N), .CHARGE_DISABLE_PIN(CD),
    .LOAD_SWITCH_CONTROL(LSC), .BAT_PERCENT(BAT_PCT), .SHIP_MODE_REQUEST(ship_req),
    .BUTTON_LONG_PRESS_ACTION(long_act), .HIGH_IMPEDANCE_REQUEST(hiz_req),
    .BATTERY_MONITOR_TRIGGER(mon_trig), .CHARGE_ENABLE_N(ce_n), .LS_I2C_ENABLE(ls_en),
    .WAKE_HOLD_SEL(wake_sel), .FAULT_READ(fault_rd), .POWER_MODE(POWER_MODE),
    .BAT_SWITCH_ON(BAT_SW), .SUPPLEMENT_ON(SUPP), .SYS_OUTPUT_ENABLE(SYS_EN),
    .MIDDLE_POWER_NODE_ON(MID_ON), .MIDDLE_POWER_NODE_PULLDOWN(MID_PD),
    .LOAD_SWITCH_ON(LS_ON), .CHARGE_ON(CHG_ON), .CHARGE_CYCLE_START(CYC_START),
    .INTERRUPT_PULSE(INT_P), .SLEEP_FAULT(FAULT), .I2C_ENABLE(I2C_EN),
    .HOST_IF_READY(HOST_RDY), .BATTERY_MONITOR_LEVEL(LEVEL), .MONITOR_BUSY(MON_BUSY));

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic wait_mode(input logic [4:0] m, input int n);
    for (int i = 0; i < n && POWER_MODE !== m; i++) cyc(1);
    chk("mode", {3'h0, m}, {3'h0, POWER_MODE});
  endtask

  task automatic t_reset();
    chk("reset mode", 8'h04, {3'h0, POWER_MODE});
    chk("reset int", 8'h00, {7'h0, INT_P});
  endtask

  // Three codes of the level field: below range, mid range, top.
  task automatic t_monitor();
    logic [6:0] pct [3] = '{7'h32, 7'h50, 7'h64};
    logic [4:0] lvl [3] = '{5'h00, 5'h0A, 5'h14};
    for (int k = 0; k < 3; k++)
    begin
      @(posedge SYS_CLK) BAT_PCT <= pct[k];
      HOST.strobe(0);
      chk("busy", 8'h01, {7'h0, MON_BUSY});
      cyc(26);
      chk("level", {3'h0, lvl[k]}, {3'h0, LEVEL});
      chk("busy end", 8'h00, {7'h0, MON_BUSY});
    end
  endtask

  task automatic press(input int n);
    @(posedge SYS_CLK) PB_N <= 1'b0;
    cyc(n);
    @(posedge SYS_CLK) PB_N <= 1'b1;
    cyc(10);
  endtask

  task automatic t_battery();
    @(posedge SYS_CLK) {BAT_UV, BAT_HY} <= 2'h0;
    cyc(4);
    chk("uvlo switch", 8'h00, {7'h0, BAT_SW});
    chk("uvlo sys", 8'h00, {7'h0, SYS_EN});
    @(posedge SYS_CLK) BAT_UV <= 1'b1;
    cyc(4);
    chk("hysteresis", 8'h00, {7'h0, BAT_SW});
    @(posedge SYS_CLK) BAT_HY <= 1'b1;
    cyc(4);
    chk("release", 8'h01, {7'h0, BAT_SW});
    chk("dgl wait", 8'h00, {7'h0, SYS_EN});
    cyc(10);
    chk("sys rise", 8'h01, {7'h0, SYS_EN});
  endtask

  task automatic t_short();
    int n;
    chk("switch on", 8'h01, {7'h0, BAT_SW});
    @(posedge SYS_CLK) SC_LIMIT <= 1'b1;
    for (n = 0; n < 20 && BAT_SW === 1'b1; n++) cyc(1);
    chk("sc trip", 8'h01, {7'h0, n >= 5 && n <= 8});
    for (n = 0; n < 40 && BAT_SW !== 1'b1; n++) cyc(1);
    chk("sc recovery", 8'h01, {7'h0, n >= 19 && n <= 21});
    @(posedge SYS_CLK) SC_LIMIT <= 1'b0;
    cyc(40);
    chk("sc cleared", 8'h01, {7'h0, BAT_SW});
  endtask

  task automatic t_hiz();
    chk("host ready", 8'h01, {7'h0, HOST_RDY});
    HOST.strobe(1);
    chk("bus off", 8'h00, {7'h0, I2C_EN});
    wait_mode(ST_HIZ, 40);
    chk("hiz sys", 8'h01, {7'h0, SYS_EN});
    chk("hiz ls", 8'h01, {7'h0, LS_ON});
    HOST.set_cfg(4'h8);
    chk("ls latched", 8'h01, {7'h0, LS_ON});
    @(posedge SYS_CLK) CD <= 1'b0;
    cyc(6);
    @(posedge SYS_CLK) CD <= 1'b1;
    wait_mode(ST_ACTBAT, 10);
    chk("bus back", 8'h01, {7'h0, I2C_EN});
    chk("ls off", 8'h00, {7'h0, LS_ON});
    @(posedge SYS_CLK) LSC <= 1'b1;
    cyc(3);
    chk("ls pin", 8'h01, {7'h0, LS_ON});
    @(posedge SYS_CLK) LSC <= 1'b0;
    HOST.set_cfg(4'hA);
  endtask

  task automatic t_ship();
    @(posedge SYS_CLK) {IN_UVLO_OK, IN_ABOVE_SLEEP} <= 2'h3;
    HOST.set_ship(1'b1);
    cyc(40);
    chk("ship refused", 8'h01, {7'h0, POWER_MODE !== ST_SHIP});
    @(posedge SYS_CLK) {IN_UVLO_OK, IN_ABOVE_SLEEP} <= 2'h0;
    cyc(2);
    chk("quiet wait", 8'h01, {7'h0, POWER_MODE !== ST_SHIP});
    wait_mode(ST_SHIP, 30);
    chk("ship switch", 8'h00, {7'h0, BAT_SW});
    chk("ship pulldown", 8'h01, {7'h0, MID_PD});
    HOST.set_ship(1'b0);
    @(posedge SYS_CLK) PB_N <= 1'b0;
    #1;
    chk("middle node", 8'h01, {7'h0, MID_ON});
    cyc(10);
    @(posedge SYS_CLK) PB_N <= 1'b1;
    cyc(10);
    chk("short press", {3'h0, ST_SHIP}, {3'h0, POWER_MODE});
    HOST.set_cfg(4'hB);
    press(40);
    chk("long hold sel", {3'h0, ST_SHIP}, {3'h0, POWER_MODE});
    HOST.set_cfg(4'hA);
    @(posedge SYS_CLK) BAT_MAX <= 1'b0;
    press(40);
    chk("low battery", {3'h0, ST_SHIP}, {3'h0, POWER_MODE});
    @(posedge SYS_CLK) BAT_MAX <= 1'b1;
    press(40);
    chk("ship exit", 8'h01, {7'h0, POWER_MODE !== ST_SHIP});
    HOST.set_cfg(4'h2);
    press(55);
    wait_mode(ST_SHIP, 30);
    press(40);
    HOST.set_cfg(4'hA);
    for (int i = 0; i < 60 && HOST_RDY !== 1'b1; i++) cyc(1);
    chk("bus after exit", 8'h01, {7'h0, I2C_EN});
  endtask

  task automatic t_sleep();
    @(posedge SYS_CLK)
    begin
      CD <= 1'b0;
      IN_UVLO_OK <= 1'b1;
      IN_ABOVE_SLEEP <= 1'b1;
    end
    wait_mode(ST_CHARGE, 20);
    chk("charging", 8'h01, {7'h0, CHG_ON});
    chk("supplement", 8'h01, {7'h0, SUPP});
    @(posedge SYS_CLK) BAT_MIN <= 1'b0;
    HOST.set_cfg(4'hE);
    chk("charge bit", 8'h00, {7'h0, CHG_ON});
    cyc(2);
    chk("below minimum", 8'h00, {7'h0, SUPP});
    chk("switch below min", 8'h00, {7'h0, BAT_SW});
    @(posedge SYS_CLK) BAT_MIN <= 1'b1;
    HOST.set_cfg(4'hA);
    @(posedge SYS_CLK) IN_ABOVE_SLEEP <= 1'b0;
    for (int i = 0; i < 10 && INT_P !== 1'b1; i++) cyc(1);
    chk("sleep mode", {3'h0, ST_SLEEP}, {3'h0, POWER_MODE});
    for (int i = 0; i < 12; i++)
    begin
      chk("int pulse", 8'h01, {7'h0, INT_P});
      cyc(1);
    end
    chk("int end", 8'h00, {7'h0, INT_P});
    HOST.strobe(2);
    chk("fault kept", 8'h01, {7'h0, FAULT});
    @(posedge SYS_CLK) IN_ABOVE_SLEEP <= 1'b1;
    for (int i = 0; i < 10 && CYC_START !== 1'b1; i++) cyc(1);
    chk("new cycle", 8'h01, {7'h0, CYC_START});
    HOST.strobe(2);
    cyc(1);
    chk("fault clear", 8'h00, {7'h0, FAULT});
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    cyc(12);
    NRST <= 1'b1;
    cyc(1);
    t_reset();
    cyc(20);
    t_monitor();
    t_battery();
    t_short();
    t_hiz();
    t_ship();
    t_sleep();
    wrap_up();
  end

  // The sequence needs under 1000 cycles; 50000 leaves ample margin.
  initial
  begin
    #500000;
    err_total++;
    wrap_up();
  end
endmodule
